//--- rtl/pcs_config_regs.sv
// PCI status/command and transmit window configuration logic
`timescale 1ns/1ps
// Contract
// - Target write-data parity error, or address parity error while not master, sets bit 31, even with parity handling off; W1C.
// - Asserting SERR sets bit 30 (W1C) and raises the transmit path error.
// - Own master transaction ending in master abort sets bit 29; W1C.
// - Own master transaction ending in target abort sets bit 28; W1C.
// - Never signal target abort; bit 27 reads zero.
// - Bits 26:25 read fixed 10b device-select timing.
// - Target PERR seen as master with response enabled sets bit 24, raises receive path error.
// - Bit 23 reads zero; no fast back-to-back across different agents.
// - Bits 7, 5, 4, 3 and 0 hardwired zero, writes ignored.
// - SERR enable and address parity error while not master drive SERR and transmit path error.
// - Parity response set asserts PERR on target write data errors; clear ignores them.
// - Master transactions start only while bus master enable bit 2 is set.
// - Memory accesses claimed only while memory space enable bit 1 is set.
// - Writable base in bits 31:27, reset zero; window writes forwarded to the link.
// - Transmit base bit 3 always reads one.
// - Transmit base bits 2:1 read 00b.
// - Transmit base bit 0 reads zero.
module pcs_config_regs #(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 32
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    input wire pcs_pkg::pcs_pci_evt_t pci_evt_i,
    input wire logic is_master_i,
    input wire logic master_req_i,
    output logic master_start_o,
    input wire logic mem_valid_i,
    input wire logic mem_write_i,
    input wire logic [ADDR_W-1:0] mem_addr_i,
    input wire logic [DATA_W-1:0] mem_data_i,
    output logic mem_claim_o,
    output logic link_tx_valid_o,
    output logic [ADDR_W-1:0] link_tx_addr_o,
    output logic [DATA_W-1:0] link_tx_data_o,
    output logic serr_o,
    output logic serr_oe_o,
    output logic perr_o,
    output logic perr_oe_o,
    output logic transmit_path_error_o,
    output logic receive_path_error_o,
    output pcs_pkg::pcs_cmd_t cmd_o
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Window decode on the top address bits only
    function automatic logic pcs_window_hit(input logic [ADDR_W-1:0] addr,
                                            input logic [pcs_pkg::PCS_BASE_W-1:0] base);
        pcs_window_hit = (addr[ADDR_W-1 -: pcs_pkg::PCS_BASE_W] == base);
    endfunction : pcs_window_hit

    // Assemble the status/command word; unlisted bits stay zero
    function automatic logic [31:0] pcs_status_word(input pcs_pkg::pcs_flags_t f,
                                                    input pcs_pkg::pcs_cmd_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[pcs_pkg::PCS_ANY_PERR_BIT] = f.any_perr;
        w[pcs_pkg::PCS_SYS_ERR_BIT] = f.sys_err;
        w[pcs_pkg::PCS_RX_MABORT_BIT] = f.rx_mabort;
        w[pcs_pkg::PCS_RX_TABORT_BIT] = f.rx_tabort;
        w[pcs_pkg::PCS_DEVSEL_LSB +: 2] = pcs_pkg::PCS_DEVSEL_TIMING;
        w[pcs_pkg::PCS_MASTER_DPERR_BIT] = f.master_dperr;
        w[pcs_pkg::PCS_SERR_EN_BIT] = c.serr_en;
        w[pcs_pkg::PCS_PERR_RESP_BIT] = c.perr_resp;
        w[pcs_pkg::PCS_BUS_MASTER_BIT] = c.bus_master;
        w[pcs_pkg::PCS_MEM_SPACE_BIT] = c.mem_space;
        pcs_status_word = w;
    endfunction : pcs_status_word

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pcs_pkg::pcs_cmd_t cmd_reg;
    pcs_pkg::pcs_flags_t flags_reg;
    pcs_pkg::pcs_flags_t flags_next;
    pcs_pkg::pcs_flags_t flags_set;
    pcs_pkg::pcs_flags_t flags_clr;
    logic [pcs_pkg::PCS_BASE_W-1:0] base_reg;
    logic wr_status;
    logic wr_base;
    logic serr_evt;
    logic perr_evt;
    logic dperr_evt;
    logic claim_hit;
    logic [31:0] base_word;

    assign wr_status = cfg_wr_i && (cfg_addr_i == pcs_pkg::PCS_STATUS_CMD_OFS);
    assign wr_base = cfg_wr_i && (cfg_addr_i == pcs_pkg::PCS_TX_BASE_OFS);

    // Error event qualification
    assign serr_evt = pci_evt_i.addr_perr && !is_master_i && cmd_reg.serr_en;
    assign perr_evt = pci_evt_i.slave_wdata_perr && cmd_reg.perr_resp;
    assign dperr_evt = pci_evt_i.target_perr_seen && is_master_i && cmd_reg.perr_resp;

    // Only writes inside the window are claimed; reads of it are left to others
    assign claim_hit = mem_valid_i && mem_write_i && cmd_reg.mem_space
                       && pcs_window_hit(mem_addr_i, base_reg);

    // Base word with its fixed low bits; the rest of the low field reads zero
    always_comb begin
        base_word = 32'h0000_0000;
        base_word[pcs_pkg::PCS_BASE_LSB +: pcs_pkg::PCS_BASE_W] = base_reg;
        base_word[pcs_pkg::PCS_PREFETCH_BIT] = pcs_pkg::PCS_PREFETCH_VAL;
        base_word[pcs_pkg::PCS_WIN_TYPE_LSB +: 2] = pcs_pkg::PCS_WIN_TYPE_VAL;
        base_word[0] = pcs_pkg::PCS_MEM_SPACE_IND;
    end

    // ------------------------------------------------------------
    // Sticky status flags
    // ------------------------------------------------------------

    // Set wins over a same-cycle write-one-to-clear so no event is lost
    always_comb begin
        flags_set.any_perr = pci_evt_i.slave_wdata_perr || (pci_evt_i.addr_perr && !is_master_i);
        flags_set.sys_err = serr_evt;
        flags_set.rx_mabort = pci_evt_i.master_abort && is_master_i;
        flags_set.rx_tabort = pci_evt_i.target_abort && is_master_i;
        flags_set.master_dperr = dperr_evt;
        flags_clr.any_perr = wr_status && cfg_be_i[3] && cfg_wdata_i[pcs_pkg::PCS_ANY_PERR_BIT];
        flags_clr.sys_err = wr_status && cfg_be_i[3] && cfg_wdata_i[pcs_pkg::PCS_SYS_ERR_BIT];
        flags_clr.rx_mabort = wr_status && cfg_be_i[3] && cfg_wdata_i[pcs_pkg::PCS_RX_MABORT_BIT];
        flags_clr.rx_tabort = wr_status && cfg_be_i[3] && cfg_wdata_i[pcs_pkg::PCS_RX_TABORT_BIT];
        flags_clr.master_dperr = wr_status && cfg_be_i[3] && cfg_wdata_i[pcs_pkg::PCS_MASTER_DPERR_BIT];
        flags_next = flags_set | (flags_reg & ~flags_clr);
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            flags_reg <= '0;
        end else if (ce_i) begin
            flags_reg <= flags_next;
        end
    end

    // ------------------------------------------------------------
    // Command enables and transmit base
    // ------------------------------------------------------------

    // Only the four enables are stored; hardwired bits have no storage at all
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cmd_reg <= '0;
        end else if (ce_i && wr_status) begin
            if (cfg_be_i[1]) begin
                cmd_reg.serr_en <= cfg_wdata_i[pcs_pkg::PCS_SERR_EN_BIT];
            end
            if (cfg_be_i[0]) begin
                cmd_reg.perr_resp <= cfg_wdata_i[pcs_pkg::PCS_PERR_RESP_BIT];
                cmd_reg.bus_master <= cfg_wdata_i[pcs_pkg::PCS_BUS_MASTER_BIT];
                cmd_reg.mem_space <= cfg_wdata_i[pcs_pkg::PCS_MEM_SPACE_BIT];
            end
        end
    end

    // Base moves only with its own byte lane
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            base_reg <= pcs_pkg::PCS_BASE_RST;
        end else if (ce_i && wr_base && cfg_be_i[3]) begin
            base_reg <= cfg_wdata_i[pcs_pkg::PCS_BASE_LSB +: pcs_pkg::PCS_BASE_W];
        end
    end

    // ------------------------------------------------------------
    // Configuration read port
    // ------------------------------------------------------------

    // Unmapped offsets read zero
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cfg_rdata_o <= 32'h0000_0000;
            cfg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            cfg_rvalid_o <= cfg_rd_i;
            if (cfg_rd_i) begin
                unique case (cfg_addr_i)
                    pcs_pkg::PCS_STATUS_CMD_OFS: cfg_rdata_o <= pcs_status_word(flags_reg, cmd_reg);
                    pcs_pkg::PCS_TX_BASE_OFS: cfg_rdata_o <= base_word;
                    default: cfg_rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // PCI error signalling
    // ------------------------------------------------------------

    // Open-drain style: value stays low, the enable does the signalling
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            serr_o <= 1'b0;
            serr_oe_o <= 1'b0;
            perr_o <= 1'b0;
            perr_oe_o <= 1'b0;
            transmit_path_error_o <= 1'b0;
            receive_path_error_o <= 1'b0;
        end else if (ce_i) begin
            serr_o <= 1'b0;
            perr_o <= 1'b0;
            serr_oe_o <= serr_evt;
            perr_oe_o <= perr_evt;
            transmit_path_error_o <= serr_evt;
            receive_path_error_o <= dperr_evt;
        end
    end

    // ------------------------------------------------------------
    // Master gating and transmit window forwarding
    // ------------------------------------------------------------

    // A request seen while disabled is dropped, not held for later
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            master_start_o <= 1'b0;
        end else if (ce_i) begin
            master_start_o <= master_req_i && cmd_reg.bus_master;
        end
    end

    // Claimed writes become link transmits one cycle later
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            mem_claim_o <= 1'b0;
            link_tx_valid_o <= 1'b0;
            link_tx_addr_o <= '0;
            link_tx_data_o <= '0;
        end else if (ce_i) begin
            mem_claim_o <= claim_hit;
            link_tx_valid_o <= claim_hit;
            if (claim_hit) begin
                link_tx_addr_o <= mem_addr_i;
                link_tx_data_o <= mem_data_i;
            end
        end
    end

    // Enables visible to the rest of the adapter
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cmd_o <= '0;
        end else if (ce_i) begin
            cmd_o <= cmd_reg;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    chk_any_perr_set: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && pci_evt_i.slave_wdata_perr |=> flags_reg.any_perr)
        else $error("any parity flag not set");

    chk_serr_pair: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        serr_oe_o |-> transmit_path_error_o && flags_reg.sys_err)
        else $error("serr without path error or flag");

    chk_serr_drive: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && pci_evt_i.addr_perr && !is_master_i && cmd_reg.serr_en |=> serr_oe_o && transmit_path_error_o)
        else $error("address parity error did not drive serr");

    chk_mabort_set: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && pci_evt_i.master_abort && is_master_i |=> flags_reg.rx_mabort)
        else $error("master abort flag not set");

    chk_tabort_set: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && pci_evt_i.target_abort && is_master_i |=> flags_reg.rx_tabort)
        else $error("target abort flag not set");

    chk_fixed_status: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        cfg_rvalid_o && $past(cfg_addr_i) == pcs_pkg::PCS_STATUS_CMD_OFS && $past(ce_i)
        |-> cfg_rdata_o[27:25] == 3'h2 && cfg_rdata_o[23] == 1'b0 && cfg_rdata_o[22:9] == 14'h0000
        && cfg_rdata_o[7] == 1'b0)
        else $error("fixed status bits wrong");

    chk_dperr_rpe: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        receive_path_error_o && $past(ce_i)
        |-> $past(pci_evt_i.target_perr_seen) && $past(cmd_reg.perr_resp) && $past(is_master_i))
        else $error("receive path error without cause");

    chk_dperr_set: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && pci_evt_i.target_perr_seen && is_master_i && cmd_reg.perr_resp
        |=> flags_reg.master_dperr && receive_path_error_o)
        else $error("master data parity flag not set");

    chk_hard_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        cfg_rvalid_o && $past(cfg_addr_i) == pcs_pkg::PCS_STATUS_CMD_OFS && $past(ce_i)
        |-> cfg_rdata_o[5:3] == 3'h0 && cfg_rdata_o[0] == 1'b0)
        else $error("hardwired command bits not zero");

    chk_serr_cause: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(serr_oe_o) |-> $past(cmd_reg.serr_en) && !$past(is_master_i))
        else $error("serr driven without enable");

    chk_perr_gate: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && pci_evt_i.slave_wdata_perr && !cmd_reg.perr_resp |=> !perr_oe_o)
        else $error("perr driven while response off");

    chk_perr_drive: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && pci_evt_i.slave_wdata_perr && cmd_reg.perr_resp |=> perr_oe_o)
        else $error("perr not driven on write data error");

    chk_perr_cause: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        perr_oe_o && $past(ce_i) |-> $past(pci_evt_i.slave_wdata_perr) && $past(cmd_reg.perr_resp))
        else $error("perr driven without cause");

    chk_master_gate: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        master_start_o |-> $past(cmd_reg.bus_master))
        else $error("master start while disabled");

    chk_claim_gate: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        mem_claim_o |-> $past(cmd_reg.mem_space) && $past(mem_write_i))
        else $error("claim while memory space off");

    chk_window_fwd: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && claim_hit |=> link_tx_valid_o && link_tx_addr_o == $past(mem_addr_i))
        else $error("window write not forwarded");

    chk_window_data: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && claim_hit |=> link_tx_data_o == $past(mem_data_i))
        else $error("window write data not forwarded");

    chk_base_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i && wr_base && cfg_be_i[3] |=> base_reg == $past(cfg_wdata_i[31:27]))
        else $error("base write did not land");

    chk_base_word: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        cfg_rvalid_o && $past(cfg_addr_i) == pcs_pkg::PCS_TX_BASE_OFS && $past(ce_i)
        |-> cfg_rdata_o[26:0] == 27'h0000008)
        else $error("base low bits wrong");

endmodule : pcs_config_regs

//--- rtl/pcs_pkg.sv
// Constants, field positions and carrier types for the PCI status/command and transmit window block
package pcs_pkg;

    // ------------------------------------------------------------
    // Configuration offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PCS_STATUS_CMD_OFS = 8'h04;
    localparam logic [7:0] PCS_TX_BASE_OFS = 8'h10;

    // ------------------------------------------------------------
    // Status/command field positions
    // ------------------------------------------------------------
    localparam int PCS_ANY_PERR_BIT = 31;
    localparam int PCS_SYS_ERR_BIT = 30;
    localparam int PCS_RX_MABORT_BIT = 29;
    localparam int PCS_RX_TABORT_BIT = 28;
    localparam int PCS_SIG_TABORT_BIT = 27;
    localparam int PCS_DEVSEL_LSB = 25;
    localparam int PCS_MASTER_DPERR_BIT = 24;
    localparam int PCS_SERR_EN_BIT = 8;
    localparam int PCS_PERR_RESP_BIT = 6;
    localparam int PCS_BUS_MASTER_BIT = 2;
    localparam int PCS_MEM_SPACE_BIT = 1;
    localparam logic [1:0] PCS_DEVSEL_TIMING = 2'h2;

    // ------------------------------------------------------------
    // Transmit window base field positions and fixed bits
    // ------------------------------------------------------------
    localparam int PCS_BASE_LSB = 27;
    localparam int PCS_BASE_W = 5;
    localparam int PCS_PREFETCH_BIT = 3;
    localparam int PCS_WIN_TYPE_LSB = 1;
    localparam logic PCS_PREFETCH_VAL = 1'b1;
    localparam logic [1:0] PCS_WIN_TYPE_VAL = 2'h0;
    localparam logic PCS_MEM_SPACE_IND = 1'b0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PCS_BASE_W-1:0] PCS_BASE_RST = 5'h00;

    // PCI side error events, one-cycle pulses
    typedef struct packed {
        logic slave_wdata_perr;
        logic addr_perr;
        logic master_abort;
        logic target_abort;
        logic target_perr_seen;
    } pcs_pci_evt_t;

    // Writable command enables
    typedef struct packed {
        logic serr_en;
        logic perr_resp;
        logic bus_master;
        logic mem_space;
    } pcs_cmd_t;

    // Sticky write-one-to-clear status flags
    typedef struct packed {
        logic any_perr;
        logic sys_err;
        logic rx_mabort;
        logic rx_tabort;
        logic master_dperr;
    } pcs_flags_t;

endpackage : pcs_pkg

//--- bench/pcs_pci_agent.sv
// Behavioural model of the PCI host and the other bus agents facing the adapter
`timescale 1ns/1ps
module pcs_pci_agent (
    input wire logic ref_clk_i,
    output pcs_pkg::pcs_pci_evt_t pci_evt_o,
    output logic is_master_o,
    output logic mem_valid_o,
    output logic mem_write_o,
    output logic [31:0] mem_addr_o,
    output logic [31:0] mem_data_o
);
    // Idle bus at time zero
    initial begin
        pci_evt_o = '0;
        is_master_o = 1'b0;
        mem_valid_o = 1'b0;
        mem_write_o = 1'b0;
        mem_addr_o = 32'h00000000;
        mem_data_o = 32'h00000000;
    end

    // One-cycle error event; mastership stays as set until the next event
    task automatic raise_event(input pcs_pkg::pcs_pci_evt_t e, input logic m);
        @(posedge ref_clk_i);
        pci_evt_o <= e;
        is_master_o <= m;
        @(posedge ref_clk_i);
        pci_evt_o <= '0;
    endtask : raise_event

    // Single address/data phase; a released bus shows inverted junk, not the old value
    task automatic mem_cycle(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        mem_valid_o <= 1'b1;
        mem_write_o <= wr;
        mem_addr_o <= a;
        mem_data_o <= d;
        @(posedge ref_clk_i);
        mem_valid_o <= 1'b0;
        mem_write_o <= ~wr;
        mem_addr_o <= ~a;
        mem_data_o <= ~d;
    endtask : mem_cycle
endmodule : pcs_pci_agent

//--- bench/tb_pcs_config_regs.sv
// Self-checking testbench for the PCI status/command and transmit window block
`timescale 1ns/1ps
module tb_pcs_config_regs;
    logic ref_clk_i, sys_rst_i, ce_i, cfg_wr_i, cfg_rd_i, master_req_i, cfg_rvalid_o, master_start_o;
    logic [7:0] cfg_addr_i;
    logic [3:0] cfg_be_i;
    logic [31:0] cfg_wdata_i, cfg_rdata_o, mem_addr_i, mem_data_i, link_tx_addr_o, link_tx_data_o;
    logic mem_valid_i, mem_write_i, is_master_i, mem_claim_o, link_tx_valid_o;
    logic serr_o, serr_oe_o, perr_o, perr_oe_o, transmit_path_error_o, receive_path_error_o;
    pcs_pkg::pcs_pci_evt_t pci_evt_i;
    pcs_pkg::pcs_cmd_t cmd_o;
    int failures = 0;
    int checked = 0;
    int cycles = 0;

    pcs_config_regs pcs_config_regs_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
        .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
        .pci_evt_i(pci_evt_i), .is_master_i(is_master_i), .master_req_i(master_req_i),
        .master_start_o(master_start_o), .mem_valid_i(mem_valid_i), .mem_write_i(mem_write_i),
        .mem_addr_i(mem_addr_i), .mem_data_i(mem_data_i), .mem_claim_o(mem_claim_o),
        .link_tx_valid_o(link_tx_valid_o), .link_tx_addr_o(link_tx_addr_o), .link_tx_data_o(link_tx_data_o),
        .serr_o(serr_o), .serr_oe_o(serr_oe_o), .perr_o(perr_o), .perr_oe_o(perr_oe_o),
        .transmit_path_error_o(transmit_path_error_o), .receive_path_error_o(receive_path_error_o),
        .cmd_o(cmd_o));

    pcs_pci_agent pcs_pci_agent_i (.ref_clk_i(ref_clk_i), .pci_evt_o(pci_evt_i), .is_master_o(is_master_i),
        .mem_valid_o(mem_valid_i), .mem_write_o(mem_write_i), .mem_addr_o(mem_addr_i), .mem_data_o(mem_data_i));

    // ----------------------------------------
    // Clock, verdict and hang guard
    // ----------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic finish_test();
        if (failures == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // Whole run needs well under 1000 cycles, so 5000 only trips on a hang
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            finish_test();
        end
    end

    // ----------------------------------------
    // Shared bus and compare tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic cfg_write(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge ref_clk_i);
        cfg_wr_i <= 1'b1;
        cfg_addr_i <= a;
        cfg_be_i <= b;
        cfg_wdata_i <= d;
        @(posedge ref_clk_i);
        cfg_wr_i <= 1'b0;
    endtask : cfg_write

    // Valid stands for one cycle after the taking edge, data until the next read, so look right after it
    task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        cfg_rd_i <= 1'b1;
        cfg_addr_i <= a;
        @(posedge ref_clk_i);
        cfg_rd_i <= 1'b0;
        #1;
        check({31'h0, cfg_rvalid_o}, 32'h1);
        check(cfg_rdata_o, exp);
    endtask : read_check

    // Event, then pins {serr_o, perr_o, serr_oe, tpe, perr_oe, rpe}, flags, and a W1C clear
    task automatic err_case(input logic [4:0] e, input logic m, input logic [5:0] pins, input logic [31:0] st,
                            input logic [31:0] idle);
        pcs_pci_agent_i.raise_event(e, m);
        #1;
        check({26'h0, serr_o, perr_o, serr_oe_o, transmit_path_error_o, perr_oe_o, receive_path_error_o},
              {26'h0, pins});
        read_check(8'h04, st);
        cfg_write(8'h04, 4'h8, 32'hff000000);
        read_check(8'h04, idle);
    endtask : err_case

    task automatic claim_check(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic hit);
        pcs_pci_agent_i.mem_cycle(wr, a, d);
        #1;
        check({30'h0, mem_claim_o, link_tx_valid_o}, {30'h0, hit, hit});
        if (hit) begin
            check(link_tx_addr_o, a);
            check(link_tx_data_o, d);
        end
    endtask : claim_check

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset_values();
        read_check(8'h04, 32'h04000000);
        read_check(8'h10, 32'h00000008);
        read_check(8'h08, 32'h00000000);
    endtask : test_reset_values

    // Hardwired bits ignore writes; lanes only write where enabled
    task automatic test_cmd_bits();
        cfg_write(8'h04, 4'hf, 32'hffffffff);
        read_check(8'h04, 32'h04000146);
        check({28'h0, cmd_o}, 32'hf);
        cfg_write(8'h04, 4'he, 32'h00000000);
        read_check(8'h04, 32'h04000046);
        cfg_write(8'h04, 4'h1, 32'h00000000);
        read_check(8'h04, 32'h04000000);
        cfg_write(8'h04, 4'hf, 32'h00000146);
    endtask : test_cmd_bits

    task automatic test_base();
        cfg_write(8'h10, 4'hf, 32'hffffffff);
        read_check(8'h10, 32'hf8000008);
        cfg_write(8'h10, 4'h7, 32'h00000000);
        read_check(8'h10, 32'hf8000008);
        cfg_write(8'h10, 4'hf, 32'h18000000);
        read_check(8'h10, 32'h18000008);
    endtask : test_base

    // A low clock enable must drop a write strobe completely
    task automatic test_clock_enable();
        @(posedge ref_clk_i);
        ce_i <= 1'b0;
        cfg_wr_i <= 1'b1;
        cfg_addr_i <= 8'h10;
        cfg_be_i <= 4'hf;
        cfg_wdata_i <= 32'h00000000;
        @(posedge ref_clk_i);
        cfg_wr_i <= 1'b0;
        ce_i <= 1'b1;
        read_check(8'h10, 32'h18000008);
    endtask : test_clock_enable

    // Window edges, reads and a disabled memory space
    task automatic test_window();
        claim_check(1'b1, 32'h1fffffff, 32'ha5a50001, 1'b1);
        claim_check(1'b1, 32'h18000000, 32'h5a5a0002, 1'b1);
        claim_check(1'b1, 32'h20000000, 32'h00000003, 1'b0);
        claim_check(1'b0, 32'h18000004, 32'h00000004, 1'b0);
        cfg_write(8'h04, 4'h1, 32'h00000044);
        claim_check(1'b1, 32'h18000008, 32'h00000005, 1'b0);
        cfg_write(8'h04, 4'h1, 32'h00000046);
    endtask : test_window

    task automatic test_master_gate();
        @(posedge ref_clk_i);
        master_req_i <= 1'b1;
        @(posedge ref_clk_i);
        master_req_i <= 1'b0;
        #1;
        check({31'h0, master_start_o}, 32'h1);
        cfg_write(8'h04, 4'h1, 32'h00000042);
        master_req_i <= 1'b1;
        @(posedge ref_clk_i);
        master_req_i <= 1'b0;
        #1;
        check({31'h0, master_start_o}, 32'h0);
        cfg_write(8'h04, 4'h1, 32'h00000046);
    endtask : test_master_gate

    // All enables on, then parity response and then SERR enable turned off in turn
    task automatic test_errors();
        err_case(5'h08, 1'b0, 6'h0c, 32'hc4000146, 32'h04000146);
        err_case(5'h08, 1'b1, 6'h00, 32'h04000146, 32'h04000146);
        err_case(5'h10, 1'b0, 6'h02, 32'h84000146, 32'h04000146);
        err_case(5'h04, 1'b1, 6'h00, 32'h24000146, 32'h04000146);
        err_case(5'h04, 1'b0, 6'h00, 32'h04000146, 32'h04000146);
        err_case(5'h02, 1'b1, 6'h00, 32'h14000146, 32'h04000146);
        err_case(5'h01, 1'b1, 6'h01, 32'h05000146, 32'h04000146);
        cfg_write(8'h04, 4'h1, 32'h00000006);
        err_case(5'h10, 1'b0, 6'h00, 32'h84000106, 32'h04000106);
        err_case(5'h01, 1'b1, 6'h00, 32'h04000106, 32'h04000106);
        cfg_write(8'h04, 4'h2, 32'h00000000);
        err_case(5'h08, 1'b0, 6'h00, 32'h84000006, 32'h04000006);
    endtask : test_errors

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        sys_rst_i = 1'b1;
        ce_i = 1'b1;
        cfg_wr_i = 1'b0;
        cfg_rd_i = 1'b0;
        cfg_addr_i = 8'h00;
        cfg_be_i = 4'h0;
        cfg_wdata_i = 32'h00000000;
        master_req_i = 1'b0;
        repeat (3) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        test_reset_values();
        test_cmd_bits();
        test_base();
        test_clock_enable();
        test_window();
        test_master_gate();
        test_errors();
        finish_test();
    end
endmodule : tb_pcs_config_regs
